// *** sisr_pkg.sv ***
/*
  shared constants, enumerations and carriers of the switch input status
  register bank: register indexes, byte addresses, reset values, zone codes
  and axi4-lite response codes.
  assumes one 32-bit axi4-lite register bus and one 100 mhz clock.
*/
package sisr_pkg;

  // sizes of the monitored input set
  localparam int unsigned NUM_IN     = 24;  // switch inputs 0 to 23
  localparam int unsigned NUM_SINGLE = 12;  // one-threshold adc inputs 0-11
  localparam int unsigned NUM_ZONE   = 6;   // two-threshold adc inputs 12-17
  localparam int unsigned ZONE_W     = 2;   // width of one zone code
  localparam int unsigned ADC_MODE_W = NUM_SINGLE + NUM_ZONE;
  localparam int unsigned AXI_ADDR_W = 8;   // byte address width
  localparam int unsigned AXI_DATA_W = 32;  // bus data width
  localparam int unsigned IDX_W      = 6;   // register index width

  // register indexes, byte address is four times the index
  localparam logic [IDX_W-1:0] COMP_IDX = 6'h05;  // comparator status
  localparam logic [IDX_W-1:0] ADC0_IDX = 6'h06;  // adc status, low half
  localparam logic [IDX_W-1:0] CTRL_IDX = 6'h10;  // update enables
  localparam logic [AXI_ADDR_W-1:0] COMP_ADDR = {COMP_IDX, 2'b00};
  localparam logic [AXI_ADDR_W-1:0] ADC0_ADDR = {ADC0_IDX, 2'b00};
  localparam logic [AXI_ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};

  // values after reset
  localparam logic [NUM_IN-1:0] STAT_RST = 24'h000000;  // both status regs
  localparam logic [1:0]        CTRL_RST = 2'h3;        // updates enabled

  // control register field positions
  localparam int unsigned CTRL_COMP_EN = 0;  // comparator updates allowed
  localparam int unsigned CTRL_ADC_EN  = 1;  // adc updates allowed

  // zone codes of the two-threshold inputs, code 3 is never made
  localparam logic [ZONE_W-1:0] ZONE_LOW  = 2'h0;  // below lower threshold
  localparam logic [ZONE_W-1:0] ZONE_MID  = 2'h1;  // between the two
  localparam logic [ZONE_W-1:0] ZONE_HIGH = 2'h2;  // at or above upper
  localparam logic [ZONE_W-1:0] ZONE_NONE = 2'h3;  // unused code

  // axi4-lite response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // register selected by an address
  typedef enum logic [1:0] {
    SISR_SEL_NONE = 2'h0,
    SISR_SEL_COMP = 2'h1,
    SISR_SEL_ADC0 = 2'h2,
    SISR_SEL_CTRL = 2'h3
  } sisr_sel_e;

  // write channel states, gray along idle-half-resp, resp-idle flips both bits
  typedef enum logic [1:0] {
    SISR_WR_IDLE = 2'b00,
    SISR_WR_ADDR = 2'b01,
    SISR_WR_RESP = 2'b11,
    SISR_WR_DATA = 2'b10
  } sisr_wr_e;

  // read channel states
  typedef enum logic {
    SISR_RD_IDLE = 1'b0,
    SISR_RD_RESP = 1'b1
  } sisr_rd_e;

  // comparator results delivered by the detection logic
  typedef struct packed {
    logic              valid;  // one-cycle strobe, new sample
    logic [NUM_IN-1:0] above;  // 1 = input above comparator threshold
    logic [NUM_IN-1:0] mode;   // 1 = input set to comparator sensing
  } sisr_comp_in_s;

  // adc threshold results delivered by the detection logic
  typedef struct packed {
    logic                  valid;                     // new sample strobe
    logic [NUM_SINGLE-1:0] adc_single_threshold_bit;  // inputs 0-11
    logic [NUM_ZONE-1:0]   above_lower;               // inputs 12-17
    logic [NUM_ZONE-1:0]   above_upper;               // inputs 12-17
    logic [ADC_MODE_W-1:0] mode;                      // 1 = adc sensing
  } sisr_adc_in_s;

endpackage

// *** sisr_zone_enc.sv ***
/*
  encoder of two-threshold results into two-bit zone codes.
  assumes both compare flags come from the same sample on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sisr_zone_enc #(
  parameter int unsigned N = sisr_pkg::NUM_ZONE  // inputs encoded
) (
  input  wire logic [N-1:0]                   above_lower,
  input  wire logic [N-1:0]                   above_upper,
  output var  logic [N*sisr_pkg::ZONE_W-1:0]  adc_zone_code
);
  import sisr_pkg::*;

  // one encoder per input, field k sits at bits 2k+1:2k
  for (genvar k = 0; k < N; k++) begin : g_zone
    // upper wins, so a missing lower flag still gives high, never 3
    always_comb begin
      if (above_upper[k]) begin
        adc_zone_code[k*ZONE_W +: ZONE_W] = ZONE_HIGH;
      end else if (above_lower[k]) begin
        adc_zone_code[k*ZONE_W +: ZONE_W] = ZONE_MID;
      end else begin
        adc_zone_code[k*ZONE_W +: ZONE_W] = ZONE_LOW;
      end
    end
  end

endmodule // sisr_zone_enc
`default_nettype wire

// *** sisr_status_reg.sv ***
/*
  one read-only status register: takes a masked sample on an update strobe
  and holds it otherwise.
  assumes the strobe and the sample come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sisr_status_reg #(
  parameter int unsigned W = sisr_pkg::NUM_IN  // register width
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         upd,    // new sample strobe
  input  wire logic [W-1:0] mask,   // 1 = field holds a meaningful result
  input  wire logic [W-1:0] din,    // sampled results
  output var  logic [W-1:0] q       // register contents
);
  import sisr_pkg::*;

  // whole state of the register
  typedef struct packed {
    logic [W-1:0] val;  // held results
  } sisr_sreg_s;

  sisr_sreg_s st_q;  // registered state
  sisr_sreg_s st_d;  // next state

  // load only on a sample, fields of other modes read as zero
  always_comb begin
    st_d = st_q;
    if (upd) begin
      st_d.val = din & mask;
    end
  end

  // synchronous reset to all zeros
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q.val <= W'(STAT_RST);
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.val;

endmodule // sisr_status_reg
`default_nettype wire

// *** sisr_top.sv ***
/*
  switch input status register bank: comparator and low adc status
  registers behind an axi4-lite slave, plus a control register that gates
  updates.
  assumes detection results arrive on aclk with a one-cycle valid strobe,
  and an axi4-lite master that keeps to one write and one read at a time.
*/
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - one comparator bit per input, bit = input
// - comparator bit 1 above threshold, 0 below
// - fields valid only for their sensing mode
// - adc inputs 0-11 one bit, above sets
// - inputs 12-17 report a two-bit zone code
// - zone 0 low, 1 between, 2 high, never 3
// - zones packed downward, input 17 at 23-22
// - input 12 zone at bits 13-12
// - comparator status at index 5, read-only, reset 0
// - adc status at index 6, read-only, reset 0
module sisr_top (
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  // detection results
  input  wire sisr_pkg::sisr_comp_in_s             comp_in,
  input  wire sisr_pkg::sisr_adc_in_s              adc_in,
  // axi4-lite write address
  input  wire logic                                s_axi_awvalid,
  output var  logic                                s_axi_awready,
  input  wire logic [sisr_pkg::AXI_ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic [2:0]                          s_axi_awprot,
  // axi4-lite write data
  input  wire logic                                s_axi_wvalid,
  output var  logic                                s_axi_wready,
  input  wire logic [sisr_pkg::AXI_DATA_W-1:0]     s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  // axi4-lite write response
  output var  logic                                s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  output var  logic [1:0]                          s_axi_bresp,
  // axi4-lite read address
  input  wire logic                                s_axi_arvalid,
  output var  logic                                s_axi_arready,
  input  wire logic [sisr_pkg::AXI_ADDR_W-1:0]     s_axi_araddr,
  input  wire logic [2:0]                          s_axi_arprot,
  // axi4-lite read data
  output var  logic                                s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  output var  logic [sisr_pkg::AXI_DATA_W-1:0]     s_axi_rdata,
  output var  logic [1:0]                          s_axi_rresp
);
  import sisr_pkg::*;

  // whole bus-side state of the block
  typedef struct packed {
    sisr_wr_e              wr_st;    // write channel state
    logic [AXI_ADDR_W-1:0] wr_addr;  // held write address
    logic [7:0]            wr_byte;  // held low data byte
    logic                  wr_be;    // held strobe of the low byte
    logic                  awready;  // write address ready
    logic                  wready;   // write data ready
    logic                  bvalid;   // write response valid
    logic [1:0]            bresp;    // write response code
    sisr_rd_e              rd_st;    // read channel state
    logic                  arready;  // read address ready
    logic                  rvalid;   // read data valid
    logic [1:0]            rresp;    // read response code
    logic [AXI_DATA_W-1:0] rdata;    // read data
    logic [1:0]            ctrl;     // update enables
  } sisr_bus_s;

  sisr_bus_s st_q;  // registered state
  sisr_bus_s st_d;  // next state

  logic [NUM_IN-1:0]          comp_q;     // comparator status contents
  logic [NUM_IN-1:0]          adc0_q;     // adc status contents
  logic [NUM_ZONE*ZONE_W-1:0] zone_code;  // encoded zones, inputs 12-17
  logic [NUM_IN-1:0]          adc0_din;   // packed adc sample
  logic [NUM_IN-1:0]          adc0_mask;  // adc fields in adc mode
  logic                       comp_upd;   // comparator sample accepted
  logic                       adc_upd;    // adc sample accepted
  logic                       aw_hs;      // write address taken
  logic                       w_hs;       // write data taken
  logic                       ar_hs;      // read address taken

  // map a byte address onto a register, low two bits ignored
  function automatic sisr_sel_e decode(input logic [AXI_ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = a[AXI_ADDR_W-1:2];
    unique case (idx)
      COMP_IDX: decode = SISR_SEL_COMP;
      ADC0_IDX: decode = SISR_SEL_ADC0;
      CTRL_IDX: decode = SISR_SEL_CTRL;
      default:  decode = SISR_SEL_NONE;
    endcase
  endfunction

  // widen the per-input adc mode bits to cover each two-bit zone
  function automatic logic [NUM_IN-1:0] adc_mask(
    input logic [ADC_MODE_W-1:0] m
  );
    logic [NUM_IN-1:0] r;
    r = '0;
    r[NUM_SINGLE-1:0] = m[NUM_SINGLE-1:0];
    for (int k = 0; k < NUM_ZONE; k++) begin
      r[NUM_SINGLE + k*ZONE_W +: ZONE_W] = {ZONE_W{m[NUM_SINGLE + k]}};
    end
    return r;
  endfunction

  // samples are taken only while software leaves updates enabled
  assign comp_upd = comp_in.valid & st_q.ctrl[CTRL_COMP_EN];
  assign adc_upd  = adc_in.valid & st_q.ctrl[CTRL_ADC_EN];

  // zone codes for the two-threshold inputs
  sisr_zone_enc #(
    .N             (NUM_ZONE)
  ) u_zone_enc (
    .above_lower   (adc_in.above_lower),
    .above_upper   (adc_in.above_upper),
    .adc_zone_code (zone_code)
  );

  // zones above the single bits: input 12 lands at 13-12, 17 at 23-22
  assign adc0_din  = {zone_code,
                      adc_in.adc_single_threshold_bit};
  assign adc0_mask = adc_mask(adc_in.mode);

  // comparator status, bit n is input n
  sisr_status_reg #(
    .W       (NUM_IN)
  ) u_comp_reg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .upd     (comp_upd),
    .mask    (comp_in.mode),
    .din     (comp_in.above),
    .q       (comp_q)
  );

  // adc status, low half
  sisr_status_reg #(
    .W       (NUM_IN)
  ) u_adc0_reg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .upd     (adc_upd),
    .mask    (adc0_mask),
    .din     (adc0_din),
    .q       (adc0_q)
  );

  // handshakes against the registered readies
  assign aw_hs = s_axi_awvalid & st_q.awready;
  assign w_hs  = s_axi_wvalid & st_q.wready;
  assign ar_hs = s_axi_arvalid & st_q.arready;

  // bus slave next state: write path, read path, then readies
  always_comb begin
    logic [AXI_ADDR_W-1:0] waddr;   // address of the completing write
    logic [7:0]            wbyte;   // low byte of the completing write
    logic                  wbe;     // its byte strobe
    logic                  commit;  // both halves of a write are in
    waddr  = aw_hs ? s_axi_awaddr : st_q.wr_addr;
    wbyte  = w_hs ? s_axi_wdata[7:0] : st_q.wr_byte;
    wbe    = w_hs ? s_axi_wstrb[0] : st_q.wr_be;
    commit = 1'b0;
    st_d   = st_q;
    // write channel, address and data accepted in either order
    unique case (st_q.wr_st)
      SISR_WR_IDLE: begin
        if (aw_hs && w_hs) begin
          commit = 1'b1;
        end else if (aw_hs) begin
          st_d.wr_st = SISR_WR_ADDR;
        end else if (w_hs) begin
          st_d.wr_st = SISR_WR_DATA;
        end
      end
      SISR_WR_ADDR: begin
        commit = w_hs;
      end
      SISR_WR_DATA: begin
        commit = aw_hs;
      end
      SISR_WR_RESP: begin
        // response leaves when the master takes it
        if (s_axi_bready) begin
          st_d.wr_st = SISR_WR_IDLE;
        end
      end
    endcase
    // hold what arrived early
    if (aw_hs) begin
      st_d.wr_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      st_d.wr_byte = s_axi_wdata[7:0];
      st_d.wr_be   = s_axi_wstrb[0];
    end
    // a complete write acts and raises its response
    if (commit) begin
      st_d.wr_st = SISR_WR_RESP;
      unique case (decode(waddr))
        SISR_SEL_CTRL: begin
          st_d.bresp = RESP_OKAY;
          if (wbe) begin
            st_d.ctrl = wbyte[1:0];
          end
        end
        // status registers ignore writes and report it
        SISR_SEL_COMP, SISR_SEL_ADC0: begin
          st_d.bresp = RESP_SLVERR;
        end
        SISR_SEL_NONE: begin
          st_d.bresp = RESP_DECERR;
        end
      endcase
    end
    // read channel, data returned the cycle after the address
    unique case (st_q.rd_st)
      SISR_RD_IDLE: begin
        if (ar_hs) begin
          st_d.rd_st = SISR_RD_RESP;
          st_d.rresp = RESP_OKAY;
          unique case (decode(s_axi_araddr))
            SISR_SEL_COMP: begin
              st_d.rdata = AXI_DATA_W'(comp_q);
            end
            SISR_SEL_ADC0: begin
              st_d.rdata = AXI_DATA_W'(adc0_q);
            end
            SISR_SEL_CTRL: begin
              st_d.rdata = AXI_DATA_W'(st_q.ctrl);
            end
            SISR_SEL_NONE: begin
              st_d.rdata = '0;
              st_d.rresp = RESP_DECERR;
            end
          endcase
        end
      end
      SISR_RD_RESP: begin
        // the read has no side effect on any register
        if (s_axi_rready) begin
          st_d.rd_st = SISR_RD_IDLE;
        end
      end
    endcase
    // readies and valids follow the next state
    st_d.awready = (st_d.wr_st == SISR_WR_IDLE) ||
                   (st_d.wr_st == SISR_WR_DATA);
    st_d.wready  = (st_d.wr_st == SISR_WR_IDLE) ||
                   (st_d.wr_st == SISR_WR_ADDR);
    st_d.bvalid  = (st_d.wr_st == SISR_WR_RESP);
    st_d.arready = (st_d.rd_st == SISR_RD_IDLE);
    st_d.rvalid  = (st_d.rd_st == SISR_RD_RESP);
  end

  // synchronous reset, then register the next state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q.wr_st   <= SISR_WR_IDLE;
      st_q.wr_addr <= '0;
      st_q.wr_byte <= '0;
      st_q.wr_be   <= 1'b0;
      st_q.awready <= 1'b0;
      st_q.wready  <= 1'b0;
      st_q.bvalid  <= 1'b0;
      st_q.bresp   <= RESP_OKAY;
      st_q.rd_st   <= SISR_RD_IDLE;
      st_q.arready <= 1'b0;
      st_q.rvalid  <= 1'b0;
      st_q.rresp   <= RESP_OKAY;
      st_q.rdata   <= '0;
      st_q.ctrl    <= CTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state flops
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready  = st_q.wready;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rresp   = st_q.rresp;
  assign s_axi_rdata   = st_q.rdata;

  // checks on the status contents and their read path
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  comp_update_a: assert property (
    comp_upd |=> comp_q == $past(comp_in.above & comp_in.mode))
    else $error("comparator status did not take the sample");

  comp_polarity_a: assert property (
    comp_upd && comp_in.mode[0] |=> comp_q[0] == $past(comp_in.above[0]))
    else $error("comparator bit 0 has the wrong sense");

  mode_mask_a: assert property (
    adc_upd && !adc_in.mode[0] && !adc_in.mode[12] |=>
      adc0_q[0] == 1'b0 && adc0_q[13:12] == ZONE_LOW)
    else $error("field of another mode is not zero");

  adc_single_a: assert property (
    adc_upd |=> adc0_q[11:0] ==
      $past(adc_in.adc_single_threshold_bit & adc_in.mode[11:0]))
    else $error("adc single bits wrong");

  zone_mid_a: assert property (
    adc_upd && adc_in.mode[13] && adc_in.above_lower[1] &&
      !adc_in.above_upper[1] |=> adc0_q[15:14] == ZONE_MID)
    else $error("input 13 zone is not mid");

  zone_never3_a: assert property (
    adc0_q[23:22] != ZONE_NONE && adc0_q[21:20] != ZONE_NONE &&
      adc0_q[19:18] != ZONE_NONE && adc0_q[17:16] != ZONE_NONE &&
      adc0_q[15:14] != ZONE_NONE && adc0_q[13:12] != ZONE_NONE)
    else $error("zone code 3 seen");

  zone17_pack_a: assert property (
    adc_upd && adc_in.mode[17] && adc_in.above_upper[5] |=>
      adc0_q[23:22] == ZONE_HIGH)
    else $error("input 17 zone misplaced");

  zone12_pack_a: assert property (
    adc_upd && adc_in.mode[12] && adc_in.above_upper[0] |=>
      adc0_q[13:12] == ZONE_HIGH)
    else $error("input 12 zone misplaced");

  comp_read_a: assert property (
    ar_hs && decode(s_axi_araddr) == SISR_SEL_COMP |=>
      s_axi_rvalid && s_axi_rresp == RESP_OKAY &&
      s_axi_rdata == AXI_DATA_W'($past(comp_q)))
    else $error("comparator status read wrong");

  adc_read_a: assert property (
    ar_hs && decode(s_axi_araddr) == SISR_SEL_ADC0 |=>
      s_axi_rvalid && s_axi_rdata == AXI_DATA_W'($past(adc0_q)))
    else $error("adc status read wrong");

  reset_zero_a: assert property (
    $rose(aresetn) |-> comp_q == STAT_RST && adc0_q == STAT_RST)
    else $error("status not zero after reset");

  hold_stable_a: assert property (
    !comp_upd && !adc_upd |=> $stable(comp_q) && $stable(adc0_q))
    else $error("status changed without a sample");

  comp_read_c: cover property (
    ar_hs && decode(s_axi_araddr) == SISR_SEL_COMP ##1 s_axi_rready);
  adc_mid_c: cover property (adc_upd && adc_in.above_lower[5]);
  ctrl_write_c: cover property (
    s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
  split_write_c: cover property (
    st_q.wr_st == SISR_WR_DATA ##1 st_q.wr_st == SISR_WR_RESP);

endmodule // sisr_top
`default_nettype wire

// *** sisr_top_bench.sv ***
/*
  self-checking bench of the switch input status register bank: drives
  detection samples and axi4-lite reads and writes, compares read data and
  responses with values worked out here.
  assumes the sisr_pkg package and the sisr_top design are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module sisr_top_bench;
  import sisr_pkg::*;

  logic          aclk;          // 100 mhz bench clock
  logic          aresetn;       // synchronous reset, active low
  sisr_comp_in_s comp_in;       // comparator samples
  sisr_adc_in_s  adc_in;        // adc samples
  logic          awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready;
  logic [7:0]    awaddr, araddr;  // byte addresses
  logic [31:0]   wdata, rdata;    // bus data
  logic [3:0]    wstrb;           // write strobes
  logic [1:0]    bresp, rresp;    // response codes
  int            errors;          // mismatches seen
  int            checks_done;     // comparisons made
  logic [31:0]   adc_keep;        // adc status word expected to stay
  logic [23:0]   cpat [3] = '{24'ha5c3f0, 24'h5a3c0f, 24'hffffff};
  logic [23:0]   cmod [3] = '{24'hffffff, 24'hffffff, 24'h81f00c};

  // device under test
  sisr_top u_sisr_top (
    .aclk(aclk), .aresetn(aresetn), .comp_in(comp_in), .adc_in(adc_in),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp)
  );

  // free-running clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // counts, verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // compare a seen value with the expected one
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // a bounded wait that ran out ends the run
  task automatic hung();
    errors++;
    $display("[ERR] t=%0t bus answer never came", $time);
    complete_run();
  endtask

  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    if (n == 50) hung();
    check({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // axi4-lite read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    if (n == 50) hung();
    check(rdata, ed);
    check({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // one comparator sample, strobe held for one cycle
  task automatic comp_smp(input logic [23:0] ab, input logic [23:0] md);
    comp_in.above <= ab;
    comp_in.mode <= md;
    comp_in.valid <= 1'b1;
    @(posedge aclk);
    comp_in.valid <= 1'b0;
    @(posedge aclk);
  endtask

  // one adc sample, strobe held for one cycle
  task automatic adc_smp(input logic [11:0] s, input logic [5:0] lo,
                         input logic [5:0] up, input logic [17:0] md);
    adc_in.adc_single_threshold_bit <= s;
    adc_in.above_lower <= lo;
    adc_in.above_upper <= up;
    adc_in.mode <= md;
    adc_in.valid <= 1'b1;
    @(posedge aclk);
    adc_in.valid <= 1'b0;
    @(posedge aclk);
  endtask

  // expected low adc status word
  function automatic logic [31:0] adc_exp(logic [11:0] s, logic [5:0] lo,
                                          logic [5:0] up, logic [17:0] md);
    logic [31:0] r;
    r = 32'h0;
    r[11:0] = s & md[11:0];
    for (int k = 0; k < 6; k++) begin
      r[12+2*k +: 2] = !md[12+k] ? ZONE_LOW :
                       up[k] ? ZONE_HIGH : lo[k] ? ZONE_MID : ZONE_LOW;
    end
    return r;
  endfunction

  // main sequence
  initial begin
    errors = 0;
    checks_done = 0;
    aresetn = 1'b0;
    comp_in = '0;
    adc_in = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(COMP_ADDR, 32'h0, RESP_OKAY);
    rd(ADC0_ADDR, 32'h0, RESP_OKAY);
    rd(CTRL_ADDR, {30'h0, CTRL_RST}, RESP_OKAY);
    // comparator patterns, the last with a mixed sensing mode
    for (int i = 0; i < 3; i++) begin
      comp_smp(cpat[i], cmod[i]);
      rd(COMP_ADDR, {8'h0, cpat[i] & cmod[i]},
         RESP_OKAY);
    end
    // zone codes 0, 1, 2 and upper flag without lower
    adc_smp(12'ha5c, 6'b110101, 6'b100110, 18'h3ffff);
    rd(ADC0_ADDR, adc_exp(12'ha5c, 6'b110101, 6'b100110, 18'h3ffff),
       RESP_OKAY);
    // input 13 between thresholds, inputs 0 and 12 out of adc sensing
    adc_smp(12'hfff, 6'b111111, 6'b011000, 18'h2a5a4);
    adc_keep = adc_exp(12'hfff, 6'b111111, 6'b011000, 18'h2a5a4);
    rd(ADC0_ADDR, adc_keep, RESP_OKAY);
    // status registers refuse writes and keep their contents
    wr(COMP_ADDR, 32'hffffffff, 4'hf, RESP_SLVERR);
    rd(COMP_ADDR, {8'h0, cpat[2] & cmod[2]}, RESP_OKAY);
    wr(ADC0_ADDR, 32'h0, 4'hf, RESP_SLVERR);
    rd(ADC0_ADDR, adc_keep, RESP_OKAY);
    rd(8'h00, 32'h0, RESP_DECERR);
    // inputs move without a strobe, repeated reads see no change
    comp_in.above <= 24'h123456;
    comp_in.mode <= 24'hffffff;
    repeat (3) @(posedge aclk);
    rd(COMP_ADDR, {8'h0, cpat[2] & cmod[2]}, RESP_OKAY);
    rd(COMP_ADDR, {8'h0, cpat[2] & cmod[2]}, RESP_OKAY);
    // updates gated off, strobed samples are dropped
    wr(CTRL_ADDR, 32'h0, 4'hf, RESP_OKAY);
    comp_smp(24'h0f0f0f, 24'hffffff);
    adc_smp(12'h000, 6'h0, 6'h0, 18'h3ffff);
    rd(COMP_ADDR, {8'h0, cpat[2] & cmod[2]}, RESP_OKAY);
    rd(ADC0_ADDR, adc_keep, RESP_OKAY);
    wr(CTRL_ADDR, 32'h3, 4'he, RESP_OKAY);
    rd(CTRL_ADDR, 32'h0, RESP_OKAY);
    // updates back on, a new sample lands again
    wr(CTRL_ADDR, 32'h3, 4'hf, RESP_OKAY);
    comp_smp(24'h800001, 24'hffffff);
    rd(COMP_ADDR, 32'h00800001, RESP_OKAY);
    // input 12 at or above the upper threshold, input 13 between
    adc_smp(12'h5a5, 6'b000011, 6'b000001, 18'h3ffff);
    rd(ADC0_ADDR, adc_exp(12'h5a5, 6'b000011, 6'b000001, 18'h3ffff),
       RESP_OKAY);
    complete_run();
  end
endmodule // sisr_top_bench
`default_nettype wire
